/* File: hw/dhb_host_front_end.v */
// Host parallel bus front end: strap decode, strobes, data/command routing
//
// Notes on behaviour
// - Parallel transfers are accepted only while chip select is low.
// - Holding reset low clears the write byte, flag and pulse, and reloads the mode and address bit from the pins.
// - Reset acts by level; the block stays in reset while it is asserted.
// - Data/command select high marks the byte as display data.
// - Data/command select low sends the byte to the command registers.
// - In two-wire mode data/command select gives the slave address low bit.
// - 8080 writes are active low, captured on the strobe rising edge.
// - 6800 write pin selects direction: high read, low write.
// - Bus protocol is chosen from the three interface select straps.
// - 8080 read strobe low drives the bus; 6800 uses it as high enable.
// - Serial modes use data line 0 clock, line 1 data, lines 2-7 float.
`include "dhb_consts.vh"
`timescale 1ns/100ps
`default_nettype none
// Every host pin is asynchronous to clk_sys, so no logic reads a pin before two flops
module dhb_host_front_end (
	// Clock and pin reset
	input wire clk_sys,
	input wire reset,
	input wire reset_n,
	// Interface select straps
	input wire iface_sel_bit_zero,
	input wire iface_sel_bit_one,
	input wire iface_sel_bit_two,
	// Host control pins
	input wire chipSelectN,
	input wire data_command_select,
	input wire writeStrobePin,
	input wire readStrobePin,
	// Data bus pins
	input wire [7:0] dataPinIn,
	output wire [7:0] dataPinOut,
	output wire [7:0] dataPinOe,
	// Core side
	output reg [7:0] wrData_reg,
	output reg wrIsData_reg,
	output reg wrValid_reg,
	input wire [7:0] rdData,
	output wire rdStrobe,
	output reg [4:0] modeSel_reg,
	output reg slave_addr_lsb_reg,
	output wire coreReset,
	output wire serialClock,
	output wire twowire_data_in
);
	// Pin bundle: one chain keeps related pins aligned to the same edge
	wire [`DHB_PIN_W-1:0] pinRaw;
	// First synchroniser stage; only the second stage reads it
	reg [`DHB_PIN_W-1:0] pinMeta_reg;
	// Second stage; the first pin copy that logic may read
	reg [`DHB_PIN_W-1:0] pinSync_reg;
	// One cycle older copy of the second stage, for edge detection
	reg [`DHB_PIN_W-1:0] pinPrev_reg;
	// Straps zero and one in their own chain; strap two rides with the pins
	reg [`DHB_STRAP_W-1:0] strapMeta_reg;
	reg [`DHB_STRAP_W-1:0] strapSync_reg;
	// Pin reset as the core sees it, one register behind the synchroniser
	reg coreReset_reg;
	// Registered read byte and drive enable
	reg [7:0] rdOut_reg;
	reg rdOe_reg;

	// Synchronised pin levels
	wire resNSync;
	wire csNSync;
	wire dcSync;
	wire wrSync;
	wire rdSync;
	wire strapTwoSync;
	wire [7:0] dSync;
	// Previous levels of the two strobes
	wire wrPrev;
	wire rdPrev;
	// Strap code in {two, one, zero} order, as the mode codes are written
	wire [2:0] strap;
	// Mode flags and transfer qualifiers
	wire pinReset;
	wire is6800;
	wire is8080;
	wire isTwoWire;
	wire isSerial;
	wire selected;
	wire wr8080;
	wire wr6800;
	wire wrTake;
	wire rdActive8080;
	wire rdActive6800;
	wire rdDrive;
	wire rdStart8080;
	wire rdStart6800;

	// Low to high step between two successive synchronised samples
	function riseSeen;
		input lvl;
		input lvlOld;
		begin
			riseSeen = lvl & ~lvlOld;
		end
	endfunction

	// High to low step between two successive synchronised samples
	function fallSeen;
		input lvl;
		input lvlOld;
		begin
			fallSeen = ~lvl & lvlOld;
		end
	endfunction

	// Strap decode to one-hot mode flags; unknown codes select no bus at all
	function [4:0] decodeMode;
		input [2:0] code;
		begin
			case (code)
				`DHB_MODE_6800: decodeMode = `DHB_SEL_6800;
				`DHB_MODE_8080: decodeMode = `DHB_SEL_8080;
				`DHB_MODE_SPI4: decodeMode = `DHB_SEL_SPI4;
				`DHB_MODE_SPI3: decodeMode = `DHB_SEL_SPI3;
				`DHB_MODE_TWI: decodeMode = `DHB_SEL_TWI;
				default: decodeMode = `DHB_SEL_NONE;
			endcase
		end
	endfunction

	// Gather the pins; the order must match the pin bundle positions
	assign pinRaw = {reset_n, chipSelectN, data_command_select, writeStrobePin,
		readStrobePin, iface_sel_bit_two, dataPinIn};

	// Pin synchroniser; reset loads idle levels so no false strobe edge follows reset
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			pinMeta_reg <= `DHB_PIN_IDLE;
			pinSync_reg <= `DHB_PIN_IDLE;
			pinPrev_reg <= `DHB_PIN_IDLE;
		end else begin
			pinMeta_reg <= pinRaw;
			pinSync_reg <= pinMeta_reg;
			pinPrev_reg <= pinSync_reg;
		end
	end

	// Strap synchroniser; straps are static in use but still arrive on pins
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			strapMeta_reg <= `DHB_STRAP_IDLE;
			strapSync_reg <= `DHB_STRAP_IDLE;
		end else begin
			strapMeta_reg <= {iface_sel_bit_one, iface_sel_bit_zero};
			strapSync_reg <= strapMeta_reg;
		end
	end

	// Named views of the second stage
	assign resNSync = pinSync_reg[`DHB_PIN_RESN];
	assign csNSync = pinSync_reg[`DHB_PIN_CSN];
	assign dcSync = pinSync_reg[`DHB_PIN_DC];
	assign wrSync = pinSync_reg[`DHB_PIN_WR];
	assign rdSync = pinSync_reg[`DHB_PIN_RD];
	assign strapTwoSync = pinSync_reg[`DHB_PIN_STRAP2];
	assign dSync = pinSync_reg[`DHB_PIN_DHI:`DHB_PIN_DLO];
	assign wrPrev = pinPrev_reg[`DHB_PIN_WR];
	assign rdPrev = pinPrev_reg[`DHB_PIN_RD];
	// Bit two leads, so a strap of zero=0 one=0 two=1 reads as the 6800 code
	assign strap = {strapTwoSync, strapSync_reg[`DHB_STRAP_ONE],
		strapSync_reg[`DHB_STRAP_ZERO]};

	// Level reset: active for as long as the synchronised pin stays low
	assign pinReset = ~resNSync;
	// Mode flags come from the register loaded during pin reset
	assign is6800 = modeSel_reg[`DHB_MB_6800];
	assign is8080 = modeSel_reg[`DHB_MB_8080];
	assign isTwoWire = modeSel_reg[`DHB_MB_TWI];
	assign isSerial = modeSel_reg[`DHB_MB_SPI4] | modeSel_reg[`DHB_MB_SPI3]
		| isTwoWire;
	// Chip select gates every parallel transfer and every read drive; the serial outputs pass ungated
	assign selected = ~csNSync;

	// 8080 write lands on strobe rise; 6800 write on enable fall with direction low
	assign wr8080 = is8080 & selected & riseSeen(wrSync, wrPrev);
	assign wr6800 = is6800 & selected & ~wrSync & fallSeen(rdSync, rdPrev);
	assign wrTake = wr8080 | wr6800;

	// Read drive: 8080 while read strobe low, 6800 while enable high and direction high
	assign rdActive8080 = is8080 & selected & ~rdSync;
	assign rdActive6800 = is6800 & selected & wrSync & rdSync;
	assign rdDrive = rdActive8080 | rdActive6800;
	// The core sees one strobe per read, at the edge that opens it
	assign rdStart8080 = rdActive8080 & fallSeen(rdSync, rdPrev);
	assign rdStart6800 = rdActive6800 & riseSeen(rdSync, rdPrev);
	assign rdStrobe = rdStart8080 | rdStart6800;

	// Write capture and mode latch; pin reset clears the write outputs and reloads mode and address bit from the pins
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			wrData_reg <= `DHB_BYTE_ZERO;
			wrIsData_reg <= `DHB_FLAG_CLR;
			wrValid_reg <= `DHB_FLAG_CLR;
			modeSel_reg <= `DHB_SEL_NONE;
			slave_addr_lsb_reg <= `DHB_FLAG_CLR;
		end else if (pinReset) begin
			wrData_reg <= `DHB_BYTE_ZERO;
			wrIsData_reg <= `DHB_FLAG_CLR;
			wrValid_reg <= `DHB_FLAG_CLR;
			// Straps are reloaded every cycle of pin reset, so they must be stable then
			modeSel_reg <= decodeMode(strap);
			slave_addr_lsb_reg <= dcSync;
		end else begin
			wrValid_reg <= wrTake;
			if (wrTake) begin
				wrData_reg <= dSync;
				wrIsData_reg <= dcSync;
			end
			// Address bit tracks the pin in two-wire mode only
			if (isTwoWire) begin
				slave_addr_lsb_reg <= dcSync;
			end
		end
	end

	// Core reset lags one cycle, so write pulse and read drive are already off
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			coreReset_reg <= `DHB_FLAG_CLR;
		end else begin
			coreReset_reg <= pinReset;
		end
	end
	assign coreReset = coreReset_reg;

	// Read data is registered so the pins never see a glitching mux
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			rdOut_reg <= `DHB_BYTE_ZERO;
			rdOe_reg <= `DHB_FLAG_CLR;
		end else begin
			rdOut_reg <= rdData;
			rdOe_reg <= rdDrive & ~pinReset & ~isSerial;
		end
	end
	assign dataPinOut = rdOut_reg;
	// Serial modes never drive, so lines two to seven float
	assign dataPinOe = {8{rdOe_reg}};
	// Serial pins come out synchronised; the core samples them
	assign serialClock = isSerial & dSync[`DHB_BIT_SCK];
	assign twowire_data_in = isSerial & dSync[`DHB_BIT_SDA];
endmodule
`default_nettype wire

/* File: shared/dhb_consts.vh */
// Constants for the display host bus front end
`ifndef DHB_CONSTS_VH
`define DHB_CONSTS_VH
// Strap codes, bit order {two, one, zero}
`define DHB_MODE_6800 3'h4
`define DHB_MODE_8080 3'h6
`define DHB_MODE_SPI4 3'h0
`define DHB_MODE_SPI3 3'h1
`define DHB_MODE_TWI 3'h2
// Mode flag codes reported to the core
`define DHB_SEL_W 5
`define DHB_SEL_6800 5'h01
`define DHB_SEL_8080 5'h02
`define DHB_SEL_SPI4 5'h04
`define DHB_SEL_SPI3 5'h08
`define DHB_SEL_TWI 5'h10
`define DHB_SEL_NONE 5'h00
`define DHB_BYTE_ZERO 8'h00
`define DHB_LOW_MASK 8'h03
// Positions inside the synchronised pin bundle
`define DHB_PIN_W 14
`define DHB_PIN_RESN 13
`define DHB_PIN_CSN 12
`define DHB_PIN_DC 11
`define DHB_PIN_WR 10
`define DHB_PIN_RD 9
`define DHB_PIN_STRAP2 8
`define DHB_PIN_DHI 7
`define DHB_PIN_DLO 0
// Idle pin levels: reset, chip select and write strobe high
`define DHB_PIN_IDLE 14'h3400
// Strap bits zero and one in their own chain
`define DHB_STRAP_W 2
`define DHB_STRAP_ZERO 0
`define DHB_STRAP_ONE 1
`define DHB_STRAP_IDLE 2'h0
// Mode flag bit positions
`define DHB_MB_6800 0
`define DHB_MB_8080 1
`define DHB_MB_SPI4 2
`define DHB_MB_SPI3 3
`define DHB_MB_TWI 4
// Serial line positions on the data bus
`define DHB_BIT_SCK 0
`define DHB_BIT_SDA 1
`define DHB_FLAG_CLR 1'h0
`endif

/* File: sim/dhb_host.sv */
// Host bus model driving the parallel pins
`timescale 1ns/100ps
`default_nettype none
module dhb_host(input wire logic clk, output logic csN, output logic dc, output logic wr,
	output logic rd, output logic [7:0] d);
	initial {csN, dc, wr, rd, d} = 12'hF00;
	// One write, m high for 6800; lines hold 3 clk before and 4 clk after the strobe edge
	task put(input logic m, input logic c, input logic s, input logic [7:0] b);
		@(negedge clk) {csN, dc, d, wr, rd} = {s, c, b, 2'b01};
		repeat (3) @(negedge clk);
		{wr, rd} = {2{~m}};
		repeat (4) @(negedge clk);
		{csN, dc, d, wr} = {1'b1, ~c, ~b, 1'b1}; // Released lines show inverted
	endtask
	// Read strobe level, select follows it
	task rdset(input logic v);
		@(negedge clk) {csN, rd} = {v, v};
	endtask
endmodule
`default_nettype wire

/* File: sim/dhb_props_properties.sv */
// Checker for the host bus front end
`timescale 1ns/100ps
`default_nettype none
module dhb_props (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic chipSelectN,
	input wire logic data_command_select,
	input wire logic writeStrobePin,
	input wire logic readStrobePin,
	input wire logic [7:0] dataPinIn,
	input wire logic [7:0] dataPinOe,
	input wire logic [7:0] wrData_reg,
	input wire logic wrIsData_reg,
	input wire logic wrValid_reg,
	input wire logic [4:0] modeSel_reg,
	input wire logic coreReset
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	// Strobe edges that must yield a write; the synchroniser allows a cycle of slack
	sequence s_w80;
		$rose(writeStrobePin) && !chipSelectN && modeSel_reg[1] && !coreReset;
	endsequence
	sequence s_w68;
		$fell(readStrobePin) && !writeStrobePin && !chipSelectN && modeSel_reg[0]
			&& !coreReset;
	endsequence
	sequence s_pulse;
		##[2:4] wrValid_reg;
	endsequence
	a_wr_take: assert property (s_w80 |-> s_pulse)
		else $error("8080 write lost");
	a_rw_take: assert property (s_w68 |-> s_pulse)
		else $error("6800 write lost");
	a_cs_gate: assert property (wrValid_reg |-> !$past(chipSelectN, 3))
		else $error("write without chip select");
	a_dc_route: assert property (
		wrValid_reg |-> wrIsData_reg == $past(data_command_select, 3))
		else $error("data/command flag wrong");
	a_byte_take: assert property (wrValid_reg |-> wrData_reg == $past(dataPinIn, 3))
		else $error("captured byte wrong");
	a_rst_quiet: assert property (coreReset |-> !wrValid_reg && dataPinOe == 8'h00)
		else $error("activity during pin reset");
	a_mode_hot: assert property ($onehot0(modeSel_reg))
		else $error("mode flags not one-hot");
	a_ser_float: assert property (|modeSel_reg[4:2] |-> dataPinOe == 8'h00)
		else $error("data bus driven in serial mode");
endmodule
bind dhb_host_front_end dhb_props chk(.*);
`default_nettype wire

/* File: sim/display_host_bus_front_end_tb_top.sv */
// Self-checking bench for the host bus front end
`include "dhb_consts.vh"
`timescale 1ns/100ps
`default_nettype none
module display_host_bus_front_end_tb_top;
	logic clk_sys = 0, reset = 1, rstN = 0;
	logic [2:0] im = 3'h0;
	logic [7:0] b;
	logic [2:0] cd[5] = '{`DHB_MODE_SPI4, `DHB_MODE_SPI3, `DHB_MODE_TWI, `DHB_MODE_6800, `DHB_MODE_8080};
	logic [4:0] sl[5] = '{`DHB_SEL_SPI4, `DHB_SEL_SPI3, `DHB_SEL_TWI, `DHB_SEL_6800, `DHB_SEL_8080};
	wire csN, dc, wr, rd, isD, vld, sal, cRst, sck, sdi, rs;
	wire [7:0] dIn, dOut, dOe, wrD;
	wire [4:0] mode;
	int error_cnt = 0, n_tests = 0, nv = 0, ec = 0, ns = 0;
	always #10 clk_sys = ~clk_sys;
	// Count write pulses as they stand
	always @(posedge clk_sys) if (vld === 1'b1) nv++;
	// Count read start strobes to the core
	always @(posedge clk_sys) if (rs === 1'b1) ns++;
	dhb_host host(.clk(clk_sys), .csN(csN), .dc(dc), .wr(wr), .rd(rd), .d(dIn));
	dhb_host_front_end dut(.clk_sys(clk_sys), .reset(reset), .reset_n(rstN),
		.iface_sel_bit_zero(im[0]), .iface_sel_bit_one(im[1]), .iface_sel_bit_two(im[2]),
		.chipSelectN(csN), .data_command_select(dc), .writeStrobePin(wr), .readStrobePin(rd),
		.dataPinIn(dIn), .dataPinOut(dOut), .dataPinOe(dOe), .wrData_reg(wrD),
		.wrIsData_reg(isD), .wrValid_reg(vld), .rdData(8'hA5), .rdStrobe(rs),
		.modeSel_reg(mode), .slave_addr_lsb_reg(sal), .coreReset(cRst),
		.serialClock(sck), .twowire_data_in(sdi));
	task chk(input string n, input logic [7:0] e, input logic [7:0] s);
		n_tests++;
		if (s !== e) begin
			error_cnt++;
			$display("ERROR %s exp %h got %h", n, e, s);
		end
	endtask
	// Straps are only taken while the pin reset is low
	task setm(input logic [2:0] c);
		@(negedge clk_sys) {rstN, im} = {1'b0, c};
		repeat (3) @(negedge clk_sys);
		chk("coreReset", 8'h01, {7'h00, cRst});
		rstN = 1'b1;
		repeat (4) @(negedge clk_sys);
	endtask
	task end_of_test;
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#200000;
		error_cnt++;
		end_of_test;
	end
	initial begin
		repeat (2) @(negedge clk_sys);
		reset = 1'b0;
		// One write per mode; only the parallel modes may take it
		for (int i = 0; i < 5; i++) begin
			setm(cd[i]);
			b = 8'h81 << i;
			host.put(sl[i][0], i[0], 1'b0, b);
			repeat (4) @(negedge clk_sys);
			ec += int'(sl[i][1:0] != 2'b00);
			chk("mode", {3'h0, sl[i]}, {3'h0, mode});
			chk("writes", 8'(ec), 8'(nv));
			if (|sl[i][1:0]) chk("write", {b[7:1], i[0]}, {wrD[7:1], isD});
			else chk("serial", {6'h00, dIn[1:0]}, {6'h00, sdi, sck});
			if (i == 2) chk("addrLsb", 8'(dc), 8'(sal));
			$display("mode %0d done", i);
		end
		// Unselected write, then a write under a held pin reset
		host.put(1'b0, 1'b1, 1'b1, 8'h66);
		rstN = 1'b0;
		host.put(1'b0, 1'b1, 1'b0, 8'h77);
		rstN = 1'b1;
		repeat (4) @(negedge clk_sys);
		chk("refused", 8'(ec), 8'(nv));
		host.rdset(1'b0);
		repeat (5) @(negedge clk_sys);
		chk("readBus", 8'hA5, dOut & dOe);
		chk("rdStrobe", 8'h01, 8'(ns));
		host.rdset(1'b1);
		repeat (5) @(negedge clk_sys);
		chk("release", 8'h00, dOe);
		$display("hand tests done");
		end_of_test;
	end
endmodule
`default_nettype wire
